// >>> hdl/lsg_map.vh
// constants and register map of the low supply reset guard
// Function
// RL1: the monitor is enabled straight out of reset with no software action.
// RL2: the monitor is powered and watches the supply only while monitor_power_off is clear.
// RL3: with both disable bits clear, a supply below the falling trip asserts chip reset.
// RL4: in stop mode the monitor runs only when keep_on_in_stop is set.
// RL5: trip_range_high selects the 5-V range when set and the 3-V range when clear.
// RL6: power-on reset returns trip_range_high to its cleared 3-V state.
// RL7: selecting 5-V range below the 5-V rising trip enters reset at once until the supply rises.
// RL8: once triggered, reset holds until the supply rises above the rising trip.
// RL9: the external active-low reset pin is driven low while a low-supply reset is in effect.
// RL10: low_supply_flag is derived from the comparator output.
// RL11: the flag is read-only, 1 below falling trip, 0 above rising trip, held in between.
// RL12: any reset clears low_supply_flag; the code clears it on nrst only, por_n alone leaves it.
// RL13: with monitor on and resets off the flag keeps updating for polling without reset.
// RL14: the monitor raises no interrupt request of its own; the code raises irq on flag and hold events enabled in ev_mask_ff.
// RL15: when enabled the monitor stays active in wait mode and its reset ends wait mode.
// RL16: with keep_on_in_stop set the monitor stays active in stop and its reset ends stop.
// RL17: the comparator outputs pass two flip-flops before flag or reset logic reads them.
`ifndef LSG_MAP_VH
`define LSG_MAP_VH
`define LSG_ADDR_W        4
`define LSG_DATA_W        8
`define LSG_ADDR_CONFIG   4'h0
`define LSG_ADDR_STATUS   4'h1
`define LSG_ADDR_IRQ_STAT 4'h2
`define LSG_ADDR_IRQ_MASK 4'h3
`define LSG_CFG_STOP_BIT  0
`define LSG_CFG_RANGE_BIT 1
`define LSG_CFG_RSTD_BIT  2
`define LSG_CFG_PWRD_BIT  3
`define LSG_STAT_FLAG_BIT 7
`define LSG_CONFIG_RESET  8'h00
`define LSG_EV_SET_BIT    0
`define LSG_EV_CLR_BIT    1
`define LSG_EV_RST_BIT    2
`define LSG_EV_W          3
`define LSG_RANGE_SETTLE  2'h3
`define LSG_RANGE_STEP    2'h1
`define LSG_RANGE_DONE    2'h0
`endif

// >>> hdl/lsg_guard.v
// low supply reset guard: config bits, hysteretic flag, reset hold and event status
//
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`include "lsg_map.vh"
module lsg_guard
(
  // clock and resets
  input  wire                    sys_clk,
  input  wire                    nrst,
  input  wire                    por_n,
  // register port
  input  wire [`LSG_ADDR_W-1:0]  reg_addr,
  input  wire [`LSG_DATA_W-1:0]  reg_wdata,
  input  wire                    reg_wr,
  input  wire                    reg_rd,
  output reg  [`LSG_DATA_W-1:0]  reg_rdata,
  // low power state
  input  wire                    stop_mode,
  // comparator
  input  wire                    cmp_below_falling,
  input  wire                    cmp_above_rising,
  output reg                     monitor_enable,
  output reg                     range_5v,
  // resets and interrupt
  output reg                     chip_reset,
  output reg                     rst_pin_out,
  output reg                     rst_pin_oe_n,
  output reg                     irq
);

  reg                    cfg_stop_ff;
  reg                    cfg_range_ff;
  reg                    cfg_rstd_ff;
  reg                    cfg_pwrd_ff;
  reg  [1:0]             below_sync_ff;
  reg  [1:0]             above_sync_ff;
  reg                    flag_ff;
  reg                    hold_ff;
  reg                    rng_pend_ff;
  reg  [1:0]             rng_wait_ff;
  reg  [`LSG_EV_W-1:0]   ev_stat_ff;
  reg  [`LSG_EV_W-1:0]   ev_mask_ff;
  wire                   below;
  wire                   above;
  wire                   active;
  reg                    nxt_flag;
  reg                    nxt_hold;
  wire [`LSG_EV_W-1:0]   events;
  wire [`LSG_EV_W-1:0]   nxt_ev_stat;

  function wr_hit;
    input [`LSG_ADDR_W-1:0] a;
    begin
      wr_hit = reg_wr && (reg_addr == a);
    end
  endfunction

  // second stage only is read by logic
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      below_sync_ff <= 2'h0;
      above_sync_ff <= 2'h0;
    end
    else
    begin
      below_sync_ff <= {below_sync_ff[0], cmp_below_falling}; // [RL17]
      above_sync_ff <= {above_sync_ff[0], cmp_above_rising};  // [RL17]
    end
  end

  assign below  = below_sync_ff[1];
  assign above  = above_sync_ff[1];
  // wait mode leaves the monitor untouched; stop needs keep_on_in_stop
  assign active = !cfg_pwrd_ff && (!stop_mode || cfg_stop_ff); // [RL2] [RL4] [RL15] [RL16]

  // configuration; range bit survives ordinary reset, only power-on clears it
  always @(posedge sys_clk)
  begin
    if (!por_n)
      cfg_range_ff <= 1'b0; // [RL6]
    else if (wr_hit(`LSG_ADDR_CONFIG))
      cfg_range_ff <= reg_wdata[`LSG_CFG_RANGE_BIT]; // [RL5]
  end

  // a fresh 5-V selection is checked once, after the new range has passed the
  // synchroniser; a standing 5-V range keeps its normal falling/rising hysteresis
  always @(posedge sys_clk)
  begin
    if (!por_n)
    begin
      rng_pend_ff <= 1'b0;
      rng_wait_ff <= `LSG_RANGE_DONE;
    end
    else if (wr_hit(`LSG_ADDR_CONFIG) && reg_wdata[`LSG_CFG_RANGE_BIT] && !cfg_range_ff)
    begin
      rng_pend_ff <= 1'b1; // [RL7]
      rng_wait_ff <= `LSG_RANGE_SETTLE;
    end
    else if (rng_wait_ff != `LSG_RANGE_DONE)
      rng_wait_ff <= rng_wait_ff - `LSG_RANGE_STEP;
    else
      rng_pend_ff <= 1'b0;
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      cfg_stop_ff <= 1'b0;
      cfg_rstd_ff <= 1'b0;
      cfg_pwrd_ff <= 1'b0; // [RL1]
    end
    else if (wr_hit(`LSG_ADDR_CONFIG))
    begin
      cfg_stop_ff <= reg_wdata[`LSG_CFG_STOP_BIT];
      cfg_rstd_ff <= reg_wdata[`LSG_CFG_RSTD_BIT];
      cfg_pwrd_ff <= reg_wdata[`LSG_CFG_PWRD_BIT];
    end
  end

  // hysteretic flag and reset hold
  always @*
  begin
    nxt_flag = flag_ff;
    if (active && below)
      nxt_flag = 1'b1; // [RL10] [RL11] [RL13]
    else if (active && above)
      nxt_flag = 1'b0; // [RL11]
    nxt_hold = hold_ff;
    // a fresh 5-V selection below its rising trip shows up as not above
    if (active && !cfg_rstd_ff &&
        (below || (rng_pend_ff && (rng_wait_ff == `LSG_RANGE_DONE) && !above)))
      nxt_hold = 1'b1; // [RL3] [RL7]
    else if (above || !active || cfg_rstd_ff)
      nxt_hold = 1'b0; // [RL8]
  end

  // hold is kept through nrst: the chip reset it drives comes back on nrst
  always @(posedge sys_clk)
  begin
    if (!por_n)
      hold_ff <= 1'b0;
    else
      hold_ff <= nxt_hold; // [RL8]
  end

  always @(posedge sys_clk)
  begin
    if (!nrst)
      flag_ff <= 1'b0; // [RL12]
    else
      flag_ff <= nxt_flag;
  end

  // event status, write one to clear, set wins
  assign events = {nxt_hold & ~hold_ff, ~nxt_flag & flag_ff, nxt_flag & ~flag_ff};
  assign nxt_ev_stat = (ev_stat_ff &
                        ~(wr_hit(`LSG_ADDR_IRQ_STAT) ? reg_wdata[`LSG_EV_W-1:0]
                                                     : {`LSG_EV_W{1'b0}})) | events;

  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      ev_stat_ff <= {`LSG_EV_W{1'b0}};
      ev_mask_ff <= {`LSG_EV_W{1'b0}};
    end
    else
    begin
      ev_stat_ff <= nxt_ev_stat;
      if (wr_hit(`LSG_ADDR_IRQ_MASK))
        ev_mask_ff <= reg_wdata[`LSG_EV_W-1:0];
    end
  end

  // outputs, all registered
  always @(posedge sys_clk)
  begin
    if (!nrst)
    begin
      monitor_enable <= 1'b0;
      range_5v       <= 1'b0;
      irq            <= 1'b0;
      reg_rdata      <= {`LSG_DATA_W{1'b0}};
    end
    else
    begin
      monitor_enable <= active;
      range_5v       <= cfg_range_ff; // [RL5]
      // only software-enabled status bits; supply events alone never interrupt
      irq            <= |(nxt_ev_stat & ev_mask_ff); // [RL14]
      reg_rdata      <= {`LSG_DATA_W{1'b0}};
      if (reg_rd)
      begin
        case (reg_addr)
          `LSG_ADDR_CONFIG:
          begin
            reg_rdata[`LSG_CFG_STOP_BIT]  <= cfg_stop_ff;
            reg_rdata[`LSG_CFG_RANGE_BIT] <= cfg_range_ff;
            reg_rdata[`LSG_CFG_RSTD_BIT]  <= cfg_rstd_ff;
            reg_rdata[`LSG_CFG_PWRD_BIT]  <= cfg_pwrd_ff;
          end
          `LSG_ADDR_STATUS:
            reg_rdata[`LSG_STAT_FLAG_BIT] <= flag_ff; // [RL11]
          `LSG_ADDR_IRQ_STAT:
            reg_rdata[`LSG_EV_W-1:0] <= ev_stat_ff;
          `LSG_ADDR_IRQ_MASK:
            reg_rdata[`LSG_EV_W-1:0] <= ev_mask_ff;
          default:
            reg_rdata <= {`LSG_DATA_W{1'b0}};
        endcase
      end
    end
  end

  // reset outputs follow the hold even while the chip itself is in reset
  always @(posedge sys_clk)
  begin
    if (!por_n)
    begin
      chip_reset   <= 1'b0;
      rst_pin_out  <= 1'b1;
      rst_pin_oe_n <= 1'b1;
    end
    else
    begin
      chip_reset   <= nxt_hold;  // [RL3] [RL15] [RL16]
      rst_pin_out  <= 1'b0;      // [RL9]
      rst_pin_oe_n <= !nxt_hold; // [RL9]
    end
  end

endmodule // lsg_guard

// >>> tb/lsg_guard_properties.sv
// checker of the low supply reset guard ports
`timescale 1ns/1ps
`include "lsg_map.vh"
module lsg_guard_chk
(
  // clock and resets
  input wire                   sys_clk,
  input wire                   nrst,
  input wire                   por_n,
  // register read
  input wire [`LSG_ADDR_W-1:0] reg_addr,
  input wire                   reg_rd,
  input wire [`LSG_DATA_W-1:0] reg_rdata,
  // comparator and resets
  input wire                   cmp_below_falling,
  input wire                   cmp_above_rising,
  input wire                   monitor_enable,
  input wire                   range_5v,
  input wire                   chip_reset,
  input wire                   rst_pin_out,
  input wire                   rst_pin_oe_n
);
  reg  [2:0] lo_ff;
  reg  [2:0] hi_ff;
  wire       st_rd = reg_rd && reg_addr == `LSG_ADDR_STATUS && monitor_enable;
  // saturating run lengths of each comparator level
  always @(posedge sys_clk)
  begin
    lo_ff <= cmp_below_falling ? lo_ff + {2'h0, ~&lo_ff} : 3'h0;
    hi_ff <= cmp_above_rising ? hi_ff + {2'h0, ~&hi_ff} : 3'h0;
  end
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!por_n || !nrst);
  pin_follow_a: assert property (rst_pin_oe_n == !chip_reset)
    else $error("pin enable differs from chip reset");
  pin_level_a: assert property (!rst_pin_oe_n |-> !rst_pin_out)
    else $error("reset pin driven high");
  range_por_a: assert property (disable iff (1'b0) !por_n |=> !range_5v)
    else $error("range not back to 3-V");
  trip_cause_a: assert property ($rose(chip_reset) |-> !$past(cmp_above_rising, 3))
    else $error("reset with supply above rising trip");
  sync_delay_a: assert property (!chip_reset && $rose(cmp_below_falling) |=> !chip_reset [*2])
    else $error("reset faster than the synchroniser");
  hold_release_a: assert property ($fell(chip_reset) && monitor_enable |-> $past(cmp_above_rising, 3))
    else $error("reset released below rising trip");
  flag_set_a: assert property (st_rd && lo_ff > 3'h5 |=> reg_rdata[`LSG_STAT_FLAG_BIT])
    else $error("flag clear below falling trip");
  flag_clear_a: assert property (st_rd && hi_ff > 3'h5 |=> !reg_rdata[`LSG_STAT_FLAG_BIT])
    else $error("flag set above rising trip");
  cover property ($rose(chip_reset));
  cover property ($fell(chip_reset));
  cover property (st_rd && lo_ff > 3'h5);
endmodule // lsg_guard_chk
bind lsg_guard lsg_guard_chk u_chk (.sys_clk, .nrst, .por_n, .reg_addr, .reg_rd, .reg_rdata,
  .cmp_below_falling, .cmp_above_rising, .monitor_enable, .range_5v, .chip_reset,
  .rst_pin_out, .rst_pin_oe_n);

// >>> tb/lsg_supply_model.sv
// bandgap comparator model watching a supply given in millivolts
`timescale 1ns/1ps
module lsg_supply_model
#(
  parameter logic [15:0] FALL3 = 16'hA8C,
  parameter logic [15:0] RISE3 = 16'hAF0,
  parameter logic [15:0] FALL5 = 16'h1068,
  parameter logic [15:0] RISE5 = 16'h10CC
)
(
  // supply level
  input  wire logic [15:0] vdd_mv,
  // control and comparator outputs
  input  wire logic        monitor_enable,
  input  wire logic        range_5v,
  output logic             cmp_below_falling,
  output logic             cmp_above_rising
);
  // an unpowered comparator reports neither trip
  always @*
  begin
    cmp_below_falling = monitor_enable && vdd_mv < (range_5v ? FALL5 : FALL3);
    cmp_above_rising = monitor_enable && vdd_mv > (range_5v ? RISE5 : RISE3);
  end
endmodule // lsg_supply_model

// >>> tb/tb_top.sv
// self-checking bench of the low supply reset guard
`timescale 1ns/1ps
`include "lsg_map.vh"
module tb_top;
  logic       sys_clk = 0, nrst = 0, por_n = 0, reg_wr = 0, reg_rd = 0, stop_mode = 0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00, rv;
  logic [15:0] vdd_mv = 16'hCE4;
  wire        below, above, mon, rng, crst, pout, poe_n, irq;
  wire  [7:0] reg_rdata;
  int         miscompares = 0, checks_done = 0, cyc = 0;
  lsg_guard dut (.sys_clk(sys_clk), .nrst(nrst), .por_n(por_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .stop_mode(stop_mode), .cmp_below_falling(below), .cmp_above_rising(above),
    .monitor_enable(mon), .range_5v(rng), .chip_reset(crst), .rst_pin_out(pout),
    .rst_pin_oe_n(poe_n), .irq(irq));
  lsg_supply_model sup (.vdd_mv(vdd_mv), .monitor_enable(mon), .range_5v(rng),
    .cmp_below_falling(below), .cmp_above_rising(above));
  initial
  begin
    forever #5 sys_clk = ~sys_clk;
  end
  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      miscompares++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    wt(1);
    reg_wr <= 1'b0;
    wt(1);
  endtask
  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [3:0] a, input logic [7:0] e, input string nm);
    reg_addr <= a;
    reg_rd <= 1'b1;
    wt(1);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
    chk(nm, rv, e);
    wt(1);
  endtask
  initial
  begin
    wt(10);
    nrst <= 1'b1;
    por_n <= 1'b1;
    wt(6);
    rchk(`LSG_ADDR_CONFIG, 8'h00, "config");
    chk("monitor", {7'h0, mon}, 8'h01);
    wr(`LSG_ADDR_STATUS, 8'h80);
    rchk(`LSG_ADDR_STATUS, 8'h00, "status");
    $display("test reset done");
    wr(`LSG_ADDR_IRQ_MASK, 8'h01);
    vdd_mv <= 16'h7D0;
    wt(8);
    rchk(`LSG_ADDR_STATUS, 8'h80, "flag low");
    chk("resets", {5'h0, pout, crst, poe_n}, 8'h02);
    chk("irq set", {7'h0, irq}, 8'h01);
    rchk(`LSG_ADDR_IRQ_STAT, 8'h05, "events");
    wr(`LSG_ADDR_IRQ_STAT, 8'h07);
    wt(2);
    chk("irq clear", {7'h0, irq}, 8'h00);
    rchk(`LSG_ADDR_IRQ_STAT, 8'h00, "events clear");
    vdd_mv <= 16'hABE;
    wt(8);
    rchk(`LSG_ADDR_STATUS, 8'h80, "flag between");
    chk("hold", {7'h0, crst}, 8'h01);
    vdd_mv <= 16'hCE4;
    wt(8);
    rchk(`LSG_ADDR_STATUS, 8'h00, "flag high");
    chk("release", {6'h0, crst, poe_n}, 8'h01);
    $display("test forced reset done");
    wr(`LSG_ADDR_CONFIG, 8'h04);
    vdd_mv <= 16'h7D0;
    wt(8);
    rchk(`LSG_ADDR_STATUS, 8'h80, "polled flag");
    chk("no reset", {7'h0, crst}, 8'h00);
    vdd_mv <= 16'hCE4;
    wr(`LSG_ADDR_CONFIG, 8'h00);
    stop_mode <= 1'b1;
    wt(3);
    chk("stop off", {7'h0, mon}, 8'h00);
    wr(`LSG_ADDR_CONFIG, 8'h01);
    vdd_mv <= 16'h7D0;
    wt(8);
    chk("stop reset", {6'h0, mon, crst}, 8'h03);
    vdd_mv <= 16'hCE4;
    wt(8);
    stop_mode <= 1'b0;
    wr(`LSG_ADDR_CONFIG, 8'h08);
    wt(2);
    chk("power off", {7'h0, mon}, 8'h00);
    $display("test modes done");
    wr(`LSG_ADDR_CONFIG, 8'h00);
    vdd_mv <= 16'h109A;
    wt(6);
    wr(`LSG_ADDR_CONFIG, 8'h02);
    wt(6);
    chk("range hold", {6'h0, rng, crst}, 8'h03);
    vdd_mv <= 16'h1388;
    wt(8);
    chk("range release", {7'h0, crst}, 8'h00);
    vdd_mv <= 16'h109A;
    wt(8);
    chk("range between", {7'h0, crst}, 8'h00);
    por_n <= 1'b0;
    nrst <= 1'b0;
    wt(2);
    por_n <= 1'b1;
    nrst <= 1'b1;
    wt(2);
    chk("range por", {7'h0, rng}, 8'h00);
    $display("test range done");
    stop_test();
  end
endmodule // tb_top
